// ==== hdl/instrument_serial_port.sv ====
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
// Behaviour
// - Bit rate is one of seventeen table rates from 50 to 115200 baud, 9600 after reset.
// - Words are 7 or 8 bits, the same for sending and receiving.
// - One or two stop bits are sent, the first is checked on receive.
// - Parity is odd, even, forced zero, forced one or absent.
// - With transmit pacing on, a received Xoff pauses sending and Xon resumes it.
// - With receive pacing on, Xoff is sent when the buffer nears full and Xon when it drains.
// - RTS mode off holds RTS low and mode on holds it high.
// - RTS buffer-space mode drives RTS high while the receive buffer has room, low when full.
// - No character starts while CTS is low.
// - DTR mode off holds DTR low and mode on holds it high.
// - DTR buffer-space mode drives DTR high while the receive buffer has room, low when full.
// - No character starts while DSR is low.
// - DTR and DSR handshaking only works with the RS232 standard selected.
// - With echo on, every received character is sent back, except Xon and Xoff taken by transmit pacing.
// - The serial port only operates when RS232 or RS422 is the selected remote path.
module instrument_serial_port
  import serial_port_pkg::*;
#(
  parameter int CLK_HZ = 250_000_000,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic rxd,
  input wire logic cts,
  input wire logic dsr,
  output logic txd,
  output logic rts,
  output logic dtr
);
  localparam int DEPTH = 2**AW;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] HI_C = (AW+1)'(DEPTH - PACE_MARGIN);
  localparam logic [AW:0] LO_C = (AW+1)'(DEPTH / 2);

  typedef struct packed {
    logic [4:0] baud;
    logic w8;
    logic stop2;
    par_t par;
    logic txp;
    logic rxp;
    mode_t rtsm;
    mode_t dtrm;
    logic echo;
    if_t ifc;
    logic pend;
    logic ok;
    logic wreq;
    logic [31:0] rdata;
    logic [1:0] cts_q;
    logic [1:0] dsr_q;
    logic [1:0] rx_q;
    rx_t rx_st;
    logic [3:0] rtk;
    logic [2:0] rbit;
    logic [7:0] rsh;
    logic rpar;
    tx_t tx_st;
    logic [3:0] ttk;
    logic [2:0] tbit;
    logic [7:0] tsh;
    logic tpar;
    logic hold_v;
    logic [7:0] hold_d;
    logic echo_v;
    logic [7:0] echo_d;
    logic pace_v;
    logic [7:0] pace_d;
    logic xoff;
    logic thr;
    logic perr;
    logic ferr;
    logic ovr;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic txd;
    logic rts;
    logic dtr;
  } st_t;

  function automatic logic [2:0] last_bit(input logic w8);
    return w8 ? 3'h7 : 3'h6;
  endfunction

  function automatic logic has_par(input par_t p);
    return p inside {P_ODD, P_EVEN, P_ZERO, P_ONE};
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic w8, input par_t p);
    logic x;
    x = ^{d[7] & w8, d[6:0]};
    case (p)
      P_ODD: return ~x;
      P_EVEN: return x;
      P_ONE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic line_level(input mode_t m, input logic f);
    return (m == M_ON) || (m == M_SPACE && !f);
  endfunction

  function automatic st_t set_ctrl(input st_t t, input logic [31:0] d);
    st_t r;
    r = t;
    r.baud = d[F_BAUD+:5];
    r.w8 = d[F_W8];
    r.stop2 = d[F_STOP2];
    r.par = par_t'(d[F_PAR+:3]);
    r.txp = d[F_TXP];
    r.rxp = d[F_RXP];
    r.rtsm = mode_t'(d[F_RTS+:2]);
    r.dtrm = mode_t'(d[F_DTR+:2]);
    r.echo = d[F_ECHO];
    r.ifc = if_t'(d[F_IF+:2]);
    return r;
  endfunction

  function automatic logic [31:0] ctrl_word(input st_t t);
    logic [31:0] d;
    d = '0;
    d[F_BAUD+:5] = t.baud;
    d[F_W8] = t.w8;
    d[F_STOP2] = t.stop2;
    d[F_PAR+:3] = t.par;
    d[F_TXP] = t.txp;
    d[F_RXP] = t.rxp;
    d[F_RTS+:2] = t.rtsm;
    d[F_DTR+:2] = t.dtrm;
    d[F_ECHO] = t.echo;
    d[F_IF+:2] = t.ifc;
    return d;
  endfunction

  function automatic logic [31:0] stat_word(input st_t t);
    logic [31:0] d;
    d = '0;
    d[S_CNT+:AW+1] = t.cnt;
    d[S_BUSY] = t.tx_st != T_IDLE;
    d[S_HOLD] = t.hold_v;
    d[S_XOFF] = t.xoff;
    d[S_PERR] = t.perr;
    d[S_FERR] = t.ferr;
    d[S_OVR] = t.ovr;
    d[S_FULL] = t.cnt == DEPTH_C;
    return d;
  endfunction

  function automatic st_t init_state();
    st_t r;
    r = '0;
    r.wreq = 1'b1;
    r.rx_q = 2'h3;
    r.txd = 1'b1;
    r = set_ctrl(r, CTRL_RST);
    r.rts = line_level(r.rtsm, 1'b0);
    r.dtr = r.ifc == IF_232 && line_level(r.dtrm, 1'b0);
    return r;
  endfunction

  localparam st_t RST_S = init_state();

  st_t s;
  st_t n;
  logic tick;
  logic [7:0] mrd;
  logic mwe;
  logic push;
  logic pop;
  logic act;
  logic full;
  logic inhibit;
  logic start;
  logic got;
  logic tx_last;
  logic [7:0] rch;

  serial_rate_gen #(.CLK_HZ(CLK_HZ)) u_rate (
    .clk(clk),
    .rst(rst),
    .sel(s.baud),
    .tick_r(tick)
  );

  serial_buffer_mem #(.W(8), .AW(AW)) u_mem (
    .clk(clk),
    .we(mwe),
    .waddr(s.wp),
    .wdata(rch),
    .raddr(s.rp),
    .rdata_r(mrd)
  );

  assign rch = s.w8 ? s.rsh : {1'b0, s.rsh[7:1]};
  assign act = s.ifc == IF_232 || s.ifc == IF_422;
  assign full = s.cnt == DEPTH_C;
  assign inhibit = !s.cts_q[1] || (s.ifc == IF_232 && !s.dsr_q[1]);
  assign start = s.tx_st == T_IDLE && act && !inhibit && (s.pace_v || (!s.xoff && (s.echo_v || s.hold_v)));
  assign tx_last = tick && s.tx_st == T_DATA && s.ttk == 4'hF && s.tbit == last_bit(s.w8);
  assign got = act && tick && s.rx_st == R_STOP && s.rtk == 4'hF;

  always_comb begin
    n = s;
    mwe = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    n.cts_q = {s.cts_q[0], cts};
    n.dsr_q = {s.dsr_q[0], dsr};
    n.rx_q = {s.rx_q[0], rxd};

    // Seen, answered one edge later, retired on the edge that samples waitrequest low
    n.wreq = 1'b1;
    if (!s.wreq) begin
      n.pend = 1'b0;
      if (read && address == OFS_RXD && s.ok) begin
        pop = 1'b1;
        n.rp = s.rp + 1'b1;
      end
      if (write) begin
        case (address)
          OFS_CTRL: n = set_ctrl(n, writedata);
          OFS_STAT: begin
            n.perr = s.perr & ~writedata[S_PERR];
            n.ferr = s.ferr & ~writedata[S_FERR];
            n.ovr = s.ovr & ~writedata[S_OVR];
          end
          OFS_TXD: begin
            n.hold_v = 1'b1;
            n.hold_d = writedata[7:0];
          end
          default: ;
        endcase
      end
    end else if (s.pend) begin
      // A character write stalls here while the holding register is busy
      if (!(write && address == OFS_TXD && s.hold_v)) begin
        n.wreq = 1'b0;
        n.rdata = '0;
        if (read) begin
          case (address)
            OFS_CTRL: n.rdata = ctrl_word(s);
            OFS_STAT: n.rdata = stat_word(s);
            OFS_RXD: n.rdata = s.ok ? 32'(mrd) : '0;
            default: n.rdata = '0;
          endcase
        end
      end
    end else if (read || write) begin
      n.pend = 1'b1;
      // Emptiness is latched here so a character landing later cannot race the memory read
      n.ok = s.cnt != '0;
    end

    // Transmitter; pacing codes go ahead of echo and host data and ignore a held Xoff
    if (start) begin
      n.tx_st = T_START;
      n.ttk = '0;
      if (s.pace_v) begin
        n.tsh = s.pace_d;
        n.pace_v = 1'b0;
      end else if (s.echo_v) begin
        n.tsh = s.echo_d;
        n.echo_v = 1'b0;
      end else begin
        n.tsh = s.hold_d;
        n.hold_v = 1'b0;
      end
      n.tpar = par_bit(n.tsh, s.w8, s.par);
    end else if (tick && s.tx_st != T_IDLE) begin
      n.ttk = s.ttk + 1'b1;
      if (s.ttk == 4'hF) begin
        unique case (s.tx_st)
          T_IDLE: n.tx_st = T_IDLE;
          T_START: begin
            n.tx_st = T_DATA;
            n.tbit = '0;
          end
          T_DATA: begin
            n.tsh = s.tsh >> 1;
            n.tbit = s.tbit + 1'b1;
            if (tx_last) begin
              n.tx_st = has_par(s.par) ? T_PAR : T_STOP;
              n.tbit = '0;
            end
          end
          T_PAR: n.tx_st = T_STOP;
          T_STOP: begin
            n.tbit = s.tbit + 1'b1;
            if (!s.stop2 || s.tbit != '0) begin
              n.tx_st = T_IDLE;
            end
          end
        endcase
      end
    end

    // Receiver, sixteen ticks per bit, sampled mid-bit
    if (!act) begin
      n.rx_st = R_IDLE;
    end else if (tick) begin
      n.rtk = s.rtk + 1'b1;
      unique case (s.rx_st)
        R_IDLE: begin
          n.rtk = '0;
          if (!s.rx_q[1]) begin
            n.rx_st = R_START;
          end
        end
        R_START: if (s.rtk == 4'h7) begin
          n.rtk = '0;
          n.rbit = '0;
          n.rx_st = s.rx_q[1] ? R_IDLE : R_DATA;
        end
        R_DATA: if (s.rtk == 4'hF) begin
          n.rsh = {s.rx_q[1], s.rsh[7:1]};
          n.rbit = s.rbit + 1'b1;
          if (s.rbit == last_bit(s.w8)) begin
            n.rx_st = has_par(s.par) ? R_PAR : R_STOP;
          end
        end
        R_PAR: if (s.rtk == 4'hF) begin
          n.rpar = s.rx_q[1];
          n.rx_st = R_STOP;
        end
        R_STOP: if (s.rtk == 4'hF) begin
          n.rx_st = R_IDLE;
        end
      endcase
    end

    if (!s.txp) begin
      n.xoff = 1'b0;
    end
    if (got) begin
      if (!s.rx_q[1]) begin
        n.ferr = 1'b1;
      end
      if (has_par(s.par) && s.rpar != par_bit(rch, s.w8, s.par)) begin
        n.perr = 1'b1;
      end
      if (s.txp && rch == XOFF_CODE) begin
        n.xoff = 1'b1;
      end else if (s.txp && rch == XON_CODE) begin
        n.xoff = 1'b0;
      end else begin
        if (full) begin
          n.ovr = 1'b1;
        end else begin
          mwe = 1'b1;
          push = 1'b1;
          n.wp = s.wp + 1'b1;
        end
        if (s.echo) begin
          n.echo_v = 1'b1;
          n.echo_d = rch;
        end
      end
    end

    if (push && !pop) begin
      n.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = s.cnt - 1'b1;
    end

    // Hysteresis keeps the far end from seeing a burst of alternating codes
    if (!s.rxp || !act) begin
      n.thr = 1'b0;
      n.pace_v = 1'b0;
    end else if (!s.thr && s.cnt >= HI_C) begin
      n.thr = 1'b1;
      n.pace_v = 1'b1;
      n.pace_d = XOFF_CODE;
    end else if (s.thr && s.cnt <= LO_C) begin
      n.thr = 1'b0;
      n.pace_v = 1'b1;
      n.pace_d = XON_CODE;
    end

    n.txd = !(n.tx_st == T_START || (n.tx_st == T_DATA && !n.tsh[0]) || (n.tx_st == T_PAR && !n.tpar));
    n.rts = line_level(s.rtsm, full);
    n.dtr = s.ifc == IF_232 && line_level(s.dtrm, full);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  assign readdata = s.rdata;
  assign waitrequest = s.wreq;
  assign txd = s.txd;
  assign rts = s.rts;
  assign dtr = s.dtr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence tx_launch;
    s.tx_st == T_IDLE ##1 s.tx_st == T_START;
  endsequence

  sequence stop_first_end;
    tick && s.tx_st == T_STOP && s.ttk == 4'hF && s.tbit == '0;
  endsequence

  baud_reset_a: assert property ($fell(rst) |-> s.baud == 5'h0C && tick == 1'b0)
    else $error("bit rate not 9600 after reset");
  stop_two_a: assert property (stop_first_end and s.stop2 |=> s.tx_st == T_STOP)
    else $error("second stop bit missing");
  stop_one_a: assert property (stop_first_end and !s.stop2 |=> s.tx_st == T_IDLE && txd)
    else $error("extra stop bit sent");
  par_skip_a: assert property (tx_last && s.par == P_NONE |=> s.tx_st == T_STOP && txd)
    else $error("parity bit sent with parity off");
  xoff_pause_a: assert property (s.xoff && !s.pace_v && s.tx_st == T_IDLE |=> s.tx_st == T_IDLE)
    else $error("sent while paused");
  pace_quiet_a: assert property (!s.rxp |=> !s.pace_v)
    else $error("pacing code with receive pacing off");
  rts_fixed_a: assert property ((s.rtsm == M_OFF |=> !rts) and (s.rtsm == M_ON |=> rts))
    else $error("fixed RTS level wrong");
  rts_space_a: assert property (s.rtsm == M_SPACE |=> rts == !$past(full))
    else $error("RTS does not follow buffer space");
  cts_hold_a: assert property (s.tx_st == T_IDLE && !s.cts_q[1] |=> s.tx_st == T_IDLE)
    else $error("started with CTS low");
  dsr_hold_a: assert property (s.tx_st == T_IDLE && s.ifc == IF_232 && !s.dsr_q[1] |=> s.tx_st == T_IDLE)
    else $error("started with DSR low");
  dtr_422_a: assert property (s.ifc == IF_422 |=> !dtr)
    else $error("DTR driven under RS422");
  echo_back_a: assert property (got && s.echo && !s.txp |=> s.echo_v && s.echo_d == $past(rch))
    else $error("received character not queued for echo");
  start_bit_a: assert property (tx_launch |-> !txd ##1 !txd)
    else $error("start bit not low");
  xoff_code_a: assert property (s.rxp && act && !s.thr && s.cnt >= HI_C |=> s.pace_v && s.pace_d == 8'h13)
    else $error("Xoff not queued when buffer nears full");
endmodule

// ==== hdl/serial_buffer_mem.sv ====
`timescale 1ns/10ps
module serial_buffer_mem #(
  parameter int W = 8,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata_r
);
  logic [W-1:0] mem [2**AW];

  // Same-address write and read returns the old word
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
endmodule

// ==== hdl/serial_port_pkg.sv ====
package serial_port_pkg;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_TXD = 4'h8;
  localparam logic [3:0] OFS_RXD = 4'hC;

  // Control word layout
  localparam int F_BAUD = 0;
  localparam int F_W8 = 5;
  localparam int F_STOP2 = 6;
  localparam int F_PAR = 8;
  localparam int F_TXP = 11;
  localparam int F_RXP = 12;
  localparam int F_RTS = 13;
  localparam int F_DTR = 15;
  localparam int F_ECHO = 17;
  localparam int F_IF = 18;
  // 9600 baud, 8 bits, 1 stop, no parity, RTS and DTR on, RS232
  localparam logic [31:0] CTRL_RST = 32'h0004_A42C;

  // Status word layout
  localparam int S_CNT = 0;
  localparam int S_BUSY = 8;
  localparam int S_HOLD = 9;
  localparam int S_XOFF = 10;
  localparam int S_PERR = 11;
  localparam int S_FERR = 12;
  localparam int S_OVR = 13;
  localparam int S_FULL = 14;

  localparam logic [7:0] XOFF_CODE = 8'h13;
  localparam logic [7:0] XON_CODE = 8'h11;
  localparam int OVS = 16;
  localparam int PACE_MARGIN = 4;
  localparam int NUM_RATES = 17;
  localparam int RATES [NUM_RATES] = '{50, 75, 110, 150, 300, 1200, 1800, 2000, 2400, 3600, 4800, 7200, 9600,
                                       19200, 38400, 57600, 115200};

  typedef enum logic [2:0] {P_ODD, P_EVEN, P_ZERO, P_ONE, P_NONE} par_t;
  typedef enum logic [1:0] {M_OFF, M_ON, M_SPACE} mode_t;
  typedef enum logic [1:0] {IF_BUS, IF_232, IF_422} if_t;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rx_t;
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} tx_t;
endpackage

// ==== hdl/serial_rate_gen.sv ====
`timescale 1ns/10ps
module serial_rate_gen
  import serial_port_pkg::*;
#(
  parameter int CLK_HZ = 250_000_000,
  parameter int DW = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] sel,
  output logic tick_r
);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic tick;
  } rg_t;

  rg_t s;
  rg_t n;
  logic [DW-1:0] div_tab [NUM_RATES];
  logic [DW-1:0] div;

  for (genvar g = 0; g < NUM_RATES; g++) begin : g_div
    assign div_tab[g] = DW'((CLK_HZ / (OVS * RATES[g])) > 1 ? CLK_HZ / (OVS * RATES[g]) : 1);
  end
  // Undefined codes fall back to the reset rate
  assign div = (int'(sel) < NUM_RATES) ? div_tab[sel] : div_tab[CTRL_RST[F_BAUD+:5]];

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (s.cnt >= div - 1'b1) begin
      n.cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick_r = s.tick;
endmodule

// ==== verif/instrument_serial_port_tb.sv ====
`timescale 1ns/10ps
module instrument_serial_port_tb
  import serial_port_pkg::*;
;
  localparam logic [31:0] BASE = 32'h0004_A430;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic [31:0] q;
  logic waitrequest, rxd, cts, dsr, txd, rts, dtr, pb;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int nf = 0;

  // 1843200 Hz gives one clock per rate tick at 115200 baud
  instrument_serial_port #(.CLK_HZ(1_843_200)) dut_u (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .rxd(rxd), .cts(cts), .dsr(dsr), .txd(txd), .rts(rts), .dtr(dtr));
  remote_host_model host_u (.clk(clk), .txd(txd), .rxd(rxd), .cts(cts), .dsr(dsr));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until waitrequest is sampled low; the global timeout bounds the wait
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk("readdata", exp, q);
  endtask

  task automatic cfg(input logic [31:0] v);
    bus(1'b1, OFS_CTRL, v);
    repeat (2) @(posedge clk);
  endtask

  // Long enough for any frame here to finish at either bit length used
  task automatic frames(input int add, input logic [10:0] exp);
    nf += add;
    repeat (400) @(posedge clk);
    chk("frame count", 32'(nf), 32'(host_u.n_frames));
    if (add > 0) begin
      chk("frame", {21'h0, exp}, {21'h0, host_u.frame_r});
    end
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_CTRL, CTRL_RST);
    chk("pins", 32'h0000_0007, {29'h0, rts, dtr, txd});
    rd(4'h2, 32'h0000_0000);
    host_u.bit_len = 32;
    cfg(32'h0004_A42F);
    bus(1'b1, OFS_TXD, 32'h0000_000F);
    frames(1, 11'h10F);
    host_u.bit_len = 16;
    cfg(BASE);
    bus(1'b1, OFS_TXD, 32'h0000_0055);
    frames(1, 11'h155);
    for (int p = 0; p < 5; p++) begin
      host_u.nbits = (p < 4) ? 10 : 9;
      cfg(BASE & 32'hFFFF_F89F | 32'h0000_0040 | (32'(p) << F_PAR));
      bus(1'b1, OFS_TXD, 32'h0000_0035);
      pb = (p == 0) ? ~^7'h35 : (p == 1) ? ^7'h35 : (p == 3);
      frames(1, (p < 4) ? {2'b11, pb, 7'h35} : {1'b0, 2'b11, 7'h35});
    end
    host_u.nbits = 9;
    cfg(BASE);
    host_u.send(8'hA6);
    rd(OFS_RXD, 32'h0000_00A6);
    rd(OFS_RXD, 32'h0000_0000);
    host_u.cts_en <= 1'b0;
    bus(1'b1, OFS_TXD, 32'h0000_0021);
    frames(0, 11'h000);
    host_u.dsr_en <= 1'b0;
    host_u.cts_en <= 1'b1;
    frames(0, 11'h000);
    cfg(32'h0008_A430);
    frames(1, 11'h121);
    chk("dtr", 32'h0000_0000, {31'h0, dtr});
    host_u.dsr_en <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      cfg(BASE & 32'hFFFE_1FFF | (32'(m) << F_RTS) | (32'(m) << F_DTR));
      chk("rts dtr", {30'h0, {2{m[0]}}}, {30'h0, rts, dtr});
    end
    cfg(BASE ^ 32'h0001_E000);
    // The seventeenth character meets a full buffer and is dropped
    for (int i = 0; i < 17; i++) begin
      host_u.send(8'h40 + 8'(i));
      chk("rts dtr", {30'h0, {2{i < 15}}}, {30'h0, rts, dtr});
    end
    rd(OFS_STAT, 32'h0000_6010);
    bus(1'b1, OFS_STAT, 32'h0000_2000);
    rd(OFS_RXD, 32'h0000_0040);
    repeat (2) @(posedge clk);
    chk("rts dtr", 32'h0000_0003, {30'h0, rts, dtr});
    for (int i = 1; i < 16; i++) begin
      rd(OFS_RXD, 32'h0000_0040 + 32'(i));
    end
    rd(OFS_STAT, 32'h0000_0000);
    cfg(BASE | 32'h0000_0800);
    host_u.send(XOFF_CODE);
    bus(1'b1, OFS_TXD, 32'h0000_0022);
    frames(0, 11'h000);
    host_u.send(XON_CODE);
    frames(1, 11'h122);
    rd(OFS_RXD, 32'h0000_0000);
    cfg(BASE);
    host_u.send(XOFF_CODE);
    rd(OFS_RXD, 32'h0000_0013);
    cfg(BASE | 32'h0000_1000);
    for (int i = 0; i < 12; i++) begin
      host_u.send(8'h60 + 8'(i));
    end
    frames(1, 11'h113);
    for (int i = 0; i < 12; i++) begin
      rd(OFS_RXD, 32'h0000_0060 + 32'(i));
      if (i == 3) begin
        frames(1, 11'h111);
      end
    end
    cfg(BASE | 32'h0002_0000);
    host_u.send(8'h3C);
    frames(1, 11'h13C);
    rd(OFS_RXD, 32'h0000_003C);
    cfg(BASE);
    host_u.send(8'h3D);
    frames(0, 11'h000);
    rd(OFS_RXD, 32'h0000_003D);
    cfg(32'h0000_A430);
    host_u.send(8'h5A);
    rd(OFS_RXD, 32'h0000_0000);
    bus(1'b1, OFS_TXD, 32'h0000_005B);
    frames(0, 11'h000);
    cfg(32'h0008_A430);
    frames(1, 11'h15B);
    host_u.send(8'h5C);
    rd(OFS_RXD, 32'h0000_005C);
    report_and_stop();
  end
endmodule

// ==== verif/remote_host_model.sv ====
`timescale 1ns/10ps
module remote_host_model (
  input wire logic clk,
  input wire logic txd,
  output logic rxd,
  output logic cts,
  output logic dsr
);
  int bit_len = 16;
  int nbits = 9;
  int n_frames = 0;
  logic [10:0] frame_r = 11'h000;
  logic cts_en = 1'b1;
  logic dsr_en = 1'b1;

  // Handshake levels are set by the bench through these
  assign cts = cts_en;
  assign dsr = dsr_en;

  initial begin
    rxd = 1'b1;
  end

  // Start low, data LSB first, stop high; line rests high between frames
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bit_len) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  // Mid-bit sampling; frame length comes from nbits, not from the line
  always begin
    @(negedge txd);
    frame_r = 11'h000;
    repeat (bit_len / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_len) @(posedge clk);
      frame_r[i] = txd;
    end
    n_frames++;
  end
endmodule
